// file: verilog/rfs_pkg.sv
// Shared constants and types for the regulator fault supervisor
package rfs_pkg;
   // Timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned OV_DELAY_MS = 8;
   localparam int unsigned POR_DELAY_MS = 15;
   localparam int unsigned OV_DELAY_CYC = OV_DELAY_MS * (CLK_HZ / 1000);
   localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * (CLK_HZ / 1000);
   // Over-current event limits before hiccup
   localparam int unsigned OCP_LOW_LIMIT = 30;
   localparam int unsigned OCP_HIGH_LIMIT = 120;
   localparam int unsigned OCP_CNT_W = 8;
   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_INT_STATUS = 12'h008;
   localparam logic [11:0] ADDR_INT_MASK = 12'h00C;
   // Control fields
   localparam int unsigned CTRL_REG_EN_BIT = 0;
   localparam int unsigned CTRL_PWM_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   // Status fields
   localparam int unsigned ST_LATCHED_BIT = 0;
   localparam int unsigned ST_POR_BIT = 1;
   localparam int unsigned ST_POK_BIT = 2;
   localparam int unsigned ST_REGS_BIT = 3;
   localparam int unsigned ST_PWM_BIT = 4;
   localparam int unsigned ST_SHORT_BIT = 5;
   localparam int unsigned ST_OV5_BIT = 6;
   localparam int unsigned ST_LVOV_BIT = 7;
   localparam int unsigned ST_W = 8;
   // Interrupt fields
   localparam int unsigned IRQ_SHORT_BIT = 0;
   localparam int unsigned IRQ_OV5_BIT = 1;
   localparam int unsigned IRQ_LATCH_BIT = 2;
   localparam int unsigned IRQ_HIC_CORE_BIT = 3;
   localparam int unsigned IRQ_HIC_PRE_BIT = 4;
   localparam int unsigned IRQ_POR_FALL_BIT = 5;
   localparam int unsigned IRQ_POK_FALL_BIT = 6;
   localparam int unsigned IRQ_W = 7;
   localparam logic [6:0] IRQ_MASK_RESET = 7'h00;

   // Comparator levels from the analog monitors, all active high
   typedef struct packed {
      logic tracking_short_batt;
      logic five_ov;
      logic tracking_ov;
      logic five_uv;
      logic tracking_uv;
      logic lv_ov;
      logic core_ov;
      logic lv_uv;
      logic core_uv;
      logic core_below_low;
      logic pre_below_low;
      logic core_ocp;
      logic pre_ocp;
      logic pre_ov_high;
      logic diode_missing;
      logic switch_ilim;
   } rfs_faults_t;

   typedef enum logic [1:0] {
      RFS_RUN = 2'b01,
      RFS_LATCHED = 2'b10
   } rfs_state_t;
endpackage : rfs_pkg

// file: verilog/rfs_qual_timer.sv
// Persistence qualifier: output rises once the input has held for CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module rfs_qual_timer #(
   parameter int unsigned CYCLES = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Condition
   input wire logic cond,
   output logic done
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LIMIT = W'(CYCLES);

   initial begin
      if (CYCLES < 1) $error("rfs_qual_timer: CYCLES must be at least 1");
   end

   logic [W-1:0] cnt_q, cnt_d;
   logic done_q, done_d;

   always_comb begin
      cnt_d = cnt_q;
      done_d = done_q;
      if (!cond) begin
         // Any drop restarts the wait, so glitches never qualify
         cnt_d = '0;
         done_d = 1'b0;
      end else if (cnt_q != LIMIT) begin
         cnt_d = cnt_q + W'(1);
         done_d = (cnt_q + W'(1)) == LIMIT;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   assign done = done_q;

   qual_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(done) |-> $past(cond) && cnt_q == LIMIT)
      else $error("qualifier fired before the full delay");
endmodule : rfs_qual_timer
`default_nettype wire

// file: verilog/rfs_ocp_counter.sv
// Over-current event counter with a level-dependent hiccup limit
`timescale 1ns/1ps
`default_nettype none
module rfs_ocp_counter #(
   parameter int unsigned W = rfs_pkg::OCP_CNT_W,
   parameter int unsigned LOW_LIMIT = rfs_pkg::OCP_LOW_LIMIT,
   parameter int unsigned HIGH_LIMIT = rfs_pkg::OCP_HIGH_LIMIT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Monitor inputs
   input wire logic ocp,
   input wire logic below_low,
   input wire logic clear,
   // Result
   output logic hiccup
);
   localparam logic [W-1:0] LO = W'(LOW_LIMIT);
   localparam logic [W-1:0] HI = W'(HIGH_LIMIT);

   initial begin
      if (LOW_LIMIT < 1 || HIGH_LIMIT < LOW_LIMIT || HIGH_LIMIT >= (1 << W))
         $error("rfs_ocp_counter: limits do not fit the counter");
   end

   logic [W-1:0] cnt_q, cnt_d;
   logic prev_q, prev_d;
   logic hic_q, hic_d;
   logic [W-1:0] limit;

   always_comb begin
      limit = below_low ? LO : HI;
      prev_d = ocp;
      cnt_d = cnt_q;
      hic_d = 1'b0;
      if (clear) begin
         cnt_d = '0;
      end else if (ocp && !prev_q) begin
         if (cnt_q + W'(1) >= limit) begin
            cnt_d = '0;
            hic_d = 1'b1;
         end else begin
            cnt_d = cnt_q + W'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         prev_q <= 1'b0;
         hic_q <= 1'b0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         prev_q <= prev_d;
         hic_q <= hic_d;
      end
   end

   assign hiccup = hic_q;

   ocp_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      cnt_q < HI)
      else $error("over-current count passed the upper limit");
   ocp_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && below_low && !clear && ocp && !prev_q && cnt_q == LO - W'(1)) |=> hic_q)
      else $error("no hiccup at the low-level event limit");
endmodule : rfs_ocp_counter
`default_nettype wire

// file: verilog/rfs_supervisor.sv
// Top of the regulator fault supervisor with its APB register file
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - A tracking rail shorted to battery pulls power good low at once and, after the over-voltage delay, also pulls reset low and stops all regulators, unlatched.
// - A five-volt over-voltage held past the delay pulls power good low, leaves reset alone and latches nothing.
// - A low-volt or core over-voltage held past the delay pulls reset low, stops all regulators and latches.
// - A five-volt under-voltage pulls power good low only, unlatched.
// - A low-volt or core under-voltage pulls reset low only, unlatched.
// - Below the low output level, hiccup follows 30 counted over-current events.
// - Above the low output level, hiccup follows 120 counted over-current events.
// - A pre-regulator upper over-voltage stops switching of the switch node without reset or latch.
// - One detection of a missing catch diode raises the latched master fault reset.
// - A switch current above the limit raises the latched master fault reset.
// - A latched fault clears only when the enables or the supply are cycled.
// - The over-voltage qualification delay is 8 ms.
// - Reset releases 15 ms after both the core and low-volt rails are above under-voltage and the regulators are on.
module rfs_supervisor #(
   parameter int unsigned OV_DELAY_CYC = rfs_pkg::OV_DELAY_CYC,
   parameter int unsigned POR_DELAY_CYC = rfs_pkg::POR_DELAY_CYC
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Monitors and enables
   input wire rfs_pkg::rfs_faults_t faults,
   input wire logic enable_any,
   input wire logic supply_good,
   // Open-drain outputs
   output logic power_on_reset_n_o,
   output logic power_on_reset_n_oe,
   output logic five_volt_power_good_o,
   output logic five_volt_power_good_oe,
   // Regulator control
   output logic regulators_on,
   output logic pre_reg_pwm_enable,
   output logic master_fault_reset,
   output logic core_hiccup,
   output logic pre_reg_hiccup,
   // Interrupt
   output logic irq
);
   initial begin
      if (OV_DELAY_CYC < 1 || POR_DELAY_CYC < 1) $error("rfs_supervisor: delays must be >= 1");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Qualification timers

   logic short_q, ov5_q, lvov_q, rails_up_q;
   logic rails_above_uv;

   assign rails_above_uv = !faults.lv_uv && !faults.core_uv;

   rfs_qual_timer #(.CYCLES(OV_DELAY_CYC)) u_short_tmr (
      .clk(pclk), .rst_n(presetn), .ce(ce),
      .cond(faults.tracking_short_batt), .done(short_q)
   );
   rfs_qual_timer #(.CYCLES(OV_DELAY_CYC)) u_ov5_tmr (
      .clk(pclk), .rst_n(presetn), .ce(ce),
      .cond(faults.five_ov || faults.tracking_ov), .done(ov5_q)
   );
   rfs_qual_timer #(.CYCLES(OV_DELAY_CYC)) u_lvov_tmr (
      .clk(pclk), .rst_n(presetn), .ce(ce),
      .cond(faults.lv_ov || faults.core_ov), .done(lvov_q)
   );
   // Release waits on rails that are not held off by a shutdown
   rfs_qual_timer #(.CYCLES(POR_DELAY_CYC)) u_por_tmr (
      .clk(pclk), .rst_n(presetn), .ce(ce),
      .cond(rails_above_uv && regulators_on), .done(rails_up_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Hiccup counters

   logic core_hic, pre_hic;

   rfs_ocp_counter u_core_ocp (
      .clk(pclk), .rst_n(presetn), .ce(ce),
      .ocp(faults.core_ocp), .below_low(faults.core_below_low),
      .clear(!regulators_on), .hiccup(core_hic)
   );
   rfs_ocp_counter u_pre_ocp (
      .clk(pclk), .rst_n(presetn), .ce(ce),
      .ocp(faults.pre_ocp), .below_low(faults.pre_below_low),
      .clear(!regulators_on), .hiccup(pre_hic)
   );

   assign core_hiccup = core_hic;
   assign pre_reg_hiccup = pre_hic;

   ////////////////////////////////////////////////////////////////////////////////
   // Fault state and outputs

   rfs_pkg::rfs_state_t st_q, st_d;
   logic por_q, por_d, pok_q, pok_d, regs_q, regs_d, pwm_q, pwm_d;
   logic latch_set, restart;
   logic [1:0] ctrl_q, ctrl_d;

   always_comb begin
      latch_set = lvov_q || faults.diode_missing || faults.switch_ilim;
      restart = !enable_any || !supply_good;
      st_d = st_q;
      case (st_q)
         rfs_pkg::RFS_RUN: begin
            if (latch_set) st_d = rfs_pkg::RFS_LATCHED;
         end
         rfs_pkg::RFS_LATCHED: begin
            // Set wins: a cycle with the cause still present keeps the latch
            if (restart && !latch_set) st_d = rfs_pkg::RFS_RUN;
         end
         default: st_d = rfs_pkg::RFS_LATCHED;
      endcase
      regs_d = (st_d == rfs_pkg::RFS_RUN) && !short_q && enable_any
               && ctrl_q[rfs_pkg::CTRL_REG_EN_BIT];
      pwm_d = regs_d && !faults.pre_ov_high && ctrl_q[rfs_pkg::CTRL_PWM_EN_BIT];
      // Reset: rails up for the full delay, no low-side fault
      por_d = rails_up_q && rails_above_uv && !short_q && !lvov_q
              && (st_d == rfs_pkg::RFS_RUN);
      // Power good: drop at once on short or under-voltage
      pok_d = !faults.tracking_short_batt && !faults.five_uv && !faults.tracking_uv
              && !ov5_q && (st_d == rfs_pkg::RFS_RUN);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= rfs_pkg::RFS_RUN;
         por_q <= 1'b0;
         pok_q <= 1'b0;
         regs_q <= 1'b0;
         pwm_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         por_q <= por_d;
         pok_q <= pok_d;
         regs_q <= regs_d;
         pwm_q <= pwm_d;
      end
   end

   assign regulators_on = regs_q;
   assign pre_reg_pwm_enable = pwm_q;
   assign master_fault_reset = (st_q == rfs_pkg::RFS_LATCHED);
   // Open drain: pin data is low, enable pulls it
   assign power_on_reset_n_o = 1'b0;
   assign power_on_reset_n_oe = !por_q;
   assign five_volt_power_good_o = 1'b0;
   assign five_volt_power_good_oe = !pok_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Register file and interrupts

   logic [rfs_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ev;
   logic [31:0] rdata_q, rdata_d;
   logic [rfs_pkg::ST_W-1:0] status;
   logic prev_por_q, prev_pok_q, prev_lat_q, prev_short_q, prev_ov5_q;
   logic setup, wr_en, addr_ok;

   always_comb begin
      status = '0;
      status[rfs_pkg::ST_LATCHED_BIT] = master_fault_reset;
      status[rfs_pkg::ST_POR_BIT] = por_q;
      status[rfs_pkg::ST_POK_BIT] = pok_q;
      status[rfs_pkg::ST_REGS_BIT] = regs_q;
      status[rfs_pkg::ST_PWM_BIT] = pwm_q;
      status[rfs_pkg::ST_SHORT_BIT] = short_q;
      status[rfs_pkg::ST_OV5_BIT] = ov5_q;
      status[rfs_pkg::ST_LVOV_BIT] = lvov_q;
      ev = '0;
      ev[rfs_pkg::IRQ_SHORT_BIT] = short_q && !prev_short_q;
      ev[rfs_pkg::IRQ_OV5_BIT] = ov5_q && !prev_ov5_q;
      ev[rfs_pkg::IRQ_LATCH_BIT] = master_fault_reset && !prev_lat_q;
      ev[rfs_pkg::IRQ_HIC_CORE_BIT] = core_hic;
      ev[rfs_pkg::IRQ_HIC_PRE_BIT] = pre_hic;
      ev[rfs_pkg::IRQ_POR_FALL_BIT] = prev_por_q && !por_q;
      ev[rfs_pkg::IRQ_POK_FALL_BIT] = prev_pok_q && !pok_q;
      addr_ok = (paddr == rfs_pkg::ADDR_CTRL) || (paddr == rfs_pkg::ADDR_STATUS)
                || (paddr == rfs_pkg::ADDR_INT_STATUS) || (paddr == rfs_pkg::ADDR_INT_MASK);
      setup = psel && !penable;
      wr_en = psel && penable && pwrite && addr_ok && pstrb[0];
      ctrl_d = ctrl_q;
      imask_d = imask_q;
      ist_d = ist_q;
      if (wr_en && paddr == rfs_pkg::ADDR_CTRL) ctrl_d = pwdata[1:0];
      if (wr_en && paddr == rfs_pkg::ADDR_INT_MASK) imask_d = pwdata[rfs_pkg::IRQ_W-1:0];
      if (wr_en && paddr == rfs_pkg::ADDR_INT_STATUS) ist_d = ist_q & ~pwdata[rfs_pkg::IRQ_W-1:0];
      // New events win over a same-cycle clear
      ist_d = ist_d | ev;
      rdata_d = rdata_q;
      if (setup) begin
         case (paddr)
            rfs_pkg::ADDR_CTRL: rdata_d = {30'h0, ctrl_q};
            rfs_pkg::ADDR_STATUS: rdata_d = {24'h0, status};
            rfs_pkg::ADDR_INT_STATUS: rdata_d = {25'h0, ist_q};
            rfs_pkg::ADDR_INT_MASK: rdata_d = {25'h0, imask_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= rfs_pkg::CTRL_RESET;
         imask_q <= rfs_pkg::IRQ_MASK_RESET;
         ist_q <= '0;
         rdata_q <= 32'h0000_0000;
         prev_por_q <= 1'b0;
         prev_pok_q <= 1'b0;
         prev_lat_q <= 1'b0;
         prev_short_q <= 1'b0;
         prev_ov5_q <= 1'b0;
      end else if (ce) begin
         ctrl_q <= ctrl_d;
         imask_q <= imask_d;
         ist_q <= ist_d;
         rdata_q <= rdata_d;
         prev_por_q <= por_q;
         prev_pok_q <= pok_q;
         prev_lat_q <= master_fault_reset;
         prev_short_q <= short_q;
         prev_ov5_q <= ov5_q;
      end
   end

   // Zero wait states; a frozen clock enable does not stall the bus
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = rdata_q;
   assign irq = |(ist_q & imask_q);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // A restart in the first cycle may end the latch in the second
   sequence s_latch_hold;
      master_fault_reset ##1 (master_fault_reset || $past(restart));
   endsequence

   // Two quiet cycles: the qualifier drops one edge late
   sequence s_pok_quiet;
      ce && !latch_set && !master_fault_reset && !faults.tracking_short_batt
         && !faults.five_uv && !faults.tracking_uv && !faults.five_ov && !faults.tracking_ov;
   endsequence

   sequence s_frozen;
      $stable(st_q) && $stable(por_q) && $stable(pok_q) && $stable(regs_q);
   endsequence

   short_pok_a: assert property (ce && faults.tracking_short_batt |=> five_volt_power_good_oe)
      else $error("power good not pulled low on battery short");
   short_off_a: assert property (ce && short_q |=> !regulators_on
      && power_on_reset_n_oe)
      else $error("regulators left on after qualified short");
   ov5_pok_a: assert property (ce && ov5_q |=> five_volt_power_good_oe)
      else $error("power good not dropped on five-volt over-voltage");
   lvov_latch_a: assert property (ce && lvov_q |=> s_latch_hold)
      else $error("low-volt over-voltage did not latch");
   uv5_pok_a: assert property (ce && faults.five_uv |=> five_volt_power_good_oe)
      else $error("power good not dropped on five-volt under-voltage");
   uvlv_por_a: assert property (ce && faults.core_uv |=> power_on_reset_n_oe)
      else $error("reset not asserted on core under-voltage");
   pwm_stop_a: assert property (ce && faults.pre_ov_high |=> !pre_reg_pwm_enable)
      else $error("switching not stopped on pre-regulator over-voltage");
   diode_latch_a: assert property (ce && faults.diode_missing |=> master_fault_reset
      ##1 (!regulators_on || $past(restart)))
      else $error("missing diode did not shut down");
   ilim_latch_a: assert property (ce && faults.switch_ilim |=> master_fault_reset)
      else $error("switch current limit did not latch");
   latch_keep_a: assert property (master_fault_reset && enable_any && supply_good
      |=> master_fault_reset)
      else $error("latched fault cleared without a cycle");
   por_delay_a: assert property ($fell(power_on_reset_n_oe) |-> $past(rails_up_q))
      else $error("reset released before the rails were qualified");
   pok_recover_a: assert property (s_pok_quiet[*2] |=> !five_volt_power_good_oe)
      else $error("power good held low without a fault");

   // Low enable holds the fault state, reset, power good and regulator flops
   freeze_hold_a: assert property (!ce |=> s_frozen)
      else $error("state moved while the clock enable was low");

   // Events reach the pin one edge later
   irq_event_a: assert property (ce && !wr_en && |(ev & imask_q) |=> irq)
      else $error("unmasked event did not raise the interrupt");
   irq_clear_a: assert property (ce && wr_en && paddr == rfs_pkg::ADDR_INT_STATUS
      && pwdata[rfs_pkg::IRQ_W-1:0] == '1 && ev == '0 |=> !irq)
      else $error("interrupt held after a full clear");
endmodule : rfs_supervisor
`default_nettype wire

// file: testbench/rfs_host_model.sv
// Host side model of the open-drain reset and power-good lines
`timescale 1ns/1ps
`default_nettype none
module rfs_host_model (
   // Driven by the supervisor
   input wire logic por_o,
   input wire logic por_oe,
   input wire logic pok_o,
   input wire logic pok_oe,
   // Levels the host sees
   output logic reset_line,
   output logic pok_line
);
   // Board pull-ups hold a released line high, never the last driven value
   assign reset_line = por_oe ? por_o : 1'b1;
   assign pok_line = pok_oe ? pok_o : 1'b1;
endmodule : rfs_host_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking testbench of the regulator fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Short counts keep the run brief; expectations derive from them
   localparam int unsigned OV_CYC = 20;
   localparam int unsigned POR_CYC = 40;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr, por_o, por_oe, pok_o, pok_oe, regs_on, pwm_en, mfr;
   logic hic_core, hic_pre, irq, reset_line, pok_line;
   rfs_pkg::rfs_faults_t faults = '0;
   logic enable_any = 1'b1;
   logic supply_good = 1'b1;
   int err_total = 0;
   int total_checks = 0;
   int hic_n = 0;
   int cyc_n = 0;
   logic [31:0] rd;
   logic er;
   int n;

   rfs_supervisor #(.OV_DELAY_CYC(OV_CYC), .POR_DELAY_CYC(POR_CYC)) u_dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .faults(faults),
      .enable_any(enable_any), .supply_good(supply_good),
      .power_on_reset_n_o(por_o), .power_on_reset_n_oe(por_oe),
      .five_volt_power_good_o(pok_o), .five_volt_power_good_oe(pok_oe),
      .regulators_on(regs_on), .pre_reg_pwm_enable(pwm_en),
      .master_fault_reset(mfr), .core_hiccup(hic_core), .pre_reg_hiccup(hic_pre),
      .irq(irq));
   rfs_host_model u_host (.por_o(por_o), .por_oe(por_oe), .pok_o(pok_o),
      .pok_oe(pok_oe), .reset_line(reset_line), .pok_line(pok_line));

   initial begin
      forever #5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge pclk) begin
      cyc_n++;
      if (hic_core === 1'b1 || hic_pre === 1'b1) begin
         hic_n++;
      end
      if (cyc_n == 20000) begin
         err_total++;
         $display("ERROR run length expected finish seen hang");
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic tk(input int c);
      repeat (c) @(posedge pclk);
   endtask : tk

   // Holds the request until pready is sampled high, then releases it
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_por;
      n = 0;
      while (reset_line !== 1'b1 && n < POR_CYC + 20) begin
         @(negedge pclk);
         n++;
      end
      @(negedge pclk);
      chk("reset release wait", 32'h1, 32'(n >= POR_CYC));
      chk("reset line released", 32'h1, 32'(reset_line));
   endtask : wait_por

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_startup;
      wait_por();
      chk("power good up", 32'h1, 32'(pok_line));
      chk("regulators on", 32'h1, 32'(regs_on));
      apb(1'b0, rfs_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl reset", 32'(rfs_pkg::CTRL_RESET), rd);
      apb(1'b0, rfs_pkg::ADDR_INT_MASK, 32'h0);
      chk("mask reset", 32'(rfs_pkg::IRQ_MASK_RESET), rd);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped error", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
      $display("test startup done");
   endtask : t_startup

   task automatic t_lv_uv;
      @(posedge pclk);
      faults.lv_uv <= 1'b1;
      tk(2);
      @(negedge pclk);
      chk("uv reset", 32'h0, 32'(reset_line));
      chk("uv power good", 32'h1, 32'(pok_line));
      @(posedge pclk);
      faults.lv_uv <= 1'b0;
      wait_por();
      chk("uv no latch", 32'h0, 32'(mfr));
      $display("test low-volt uv done");
   endtask : t_lv_uv

   task automatic t_freeze;
      @(posedge pclk);
      ce <= 1'b0;
      faults.core_uv <= 1'b1;
      tk(3);
      @(negedge pclk);
      chk("frozen reset", 32'h1, 32'(reset_line));
      @(posedge pclk);
      ce <= 1'b1;
      tk(1);
      @(negedge pclk);
      chk("core uv reset", 32'h0, 32'(reset_line));
      @(posedge pclk);
      faults.core_uv <= 1'b0;
      wait_por();
      $display("test clock enable done");
   endtask : t_freeze

   task automatic t_five(input logic ov);
      @(posedge pclk);
      faults.five_uv <= !ov;
      faults.five_ov <= ov;
      tk(ov ? OV_CYC - 2 : 2);
      @(negedge pclk);
      chk("five-volt early", 32'(ov), 32'(pok_line));
      tk(ov ? 5 : 0);
      @(negedge pclk);
      chk("five-volt pok", 32'h0, 32'(pok_line));
      chk("five-volt reset", 32'h1, 32'(reset_line));
      @(posedge pclk);
      faults.five_uv <= 1'b0;
      faults.five_ov <= 1'b0;
      tk(3);
      @(negedge pclk);
      chk("five-volt release", 32'h1, 32'(pok_line));
      chk("five-volt no latch", 32'h0, 32'(mfr));
      $display("test five-volt fault done");
   endtask : t_five

   task automatic t_short;
      @(posedge pclk);
      faults.tracking_short_batt <= 1'b1;
      tk(2);
      @(negedge pclk);
      chk("short pok fast", 32'h0, 32'(pok_line));
      chk("short reset early", 32'h1, 32'(reset_line));
      tk(OV_CYC + 3);
      @(negedge pclk);
      chk("short reset", 32'h0, 32'(reset_line));
      chk("short regs off", 32'h0, 32'(regs_on));
      chk("short no latch", 32'h0, 32'(mfr));
      @(posedge pclk);
      faults.tracking_short_batt <= 1'b0;
      tk(3);
      @(negedge pclk);
      chk("short regs back", 32'h1, 32'(regs_on));
      wait_por();
      $display("test short to battery done");
   endtask : t_short

   // Core over-voltage, missing diode, switch limit: all latch until enables cycle
   task automatic t_latch(input int k);
      apb(1'b1, rfs_pkg::ADDR_INT_MASK, (k == 0) ? 32'h0 : 32'h4);
      @(posedge pclk);
      faults.core_ov <= (k == 0);
      faults.diode_missing <= (k == 1);
      faults.switch_ilim <= (k == 2);
      tk((k == 0) ? OV_CYC + 3 : 2);
      @(negedge pclk);
      chk("latch set", 32'h1, 32'(mfr));
      chk("latch regs off", 32'h0, 32'(regs_on));
      chk("latch reset", 32'h0, 32'(reset_line));
      chk("latch irq", 32'(k != 0), 32'(irq));
      @(posedge pclk);
      faults <= '0;
      apb(1'b0, rfs_pkg::ADDR_STATUS, 32'h0);
      chk("latch status", 32'h1, 32'(rd[rfs_pkg::ST_LATCHED_BIT]));
      @(negedge pclk);
      chk("latch holds", 32'h1, 32'(mfr));
      @(posedge pclk);
      enable_any <= 1'b0;
      @(posedge pclk);
      enable_any <= 1'b1;
      tk(2);
      @(negedge pclk);
      chk("latch cleared", 32'h0, 32'(mfr));
      wait_por();
      apb(1'b1, rfs_pkg::ADDR_INT_STATUS, 32'h0000007F);
      @(negedge pclk);
      chk("irq cleared", 32'h0, 32'(irq));
      $display("test latched fault %0d done", k);
   endtask : t_latch

   task automatic t_pwm;
      @(posedge pclk);
      faults.pre_ov_high <= 1'b1;
      tk(2);
      @(negedge pclk);
      chk("switching stop", 32'h0, 32'(pwm_en));
      chk("switching reset", 32'h1, 32'(reset_line));
      chk("switching latch", 32'h0, 32'(mfr));
      @(posedge pclk);
      faults.pre_ov_high <= 1'b0;
      tk(3);
      @(negedge pclk);
      chk("switching back", 32'h1, 32'(pwm_en));
      apb(1'b1, rfs_pkg::ADDR_CTRL, 32'h1);
      tk(1);
      @(negedge pclk);
      chk("switching off by ctrl", 32'h0, 32'(pwm_en));
      apb(1'b1, rfs_pkg::ADDR_CTRL, 32'(rfs_pkg::CTRL_RESET));
      $display("test pre-regulator ov done");
   endtask : t_pwm

   task automatic t_ocp(input logic below, input logic pre, input int limit);
      int base;
      @(posedge pclk);
      faults.core_below_low <= below;
      faults.pre_below_low <= below;
      tk(2);
      base = hic_n;
      for (int i = 1; i <= limit; i++) begin
         @(posedge pclk);
         faults.pre_ocp <= pre;
         faults.core_ocp <= !pre;
         @(posedge pclk);
         faults.pre_ocp <= 1'b0;
         faults.core_ocp <= 1'b0;
         tk(2);
         @(negedge pclk);
         chk("hiccup count", 32'(base + (i == limit)), 32'(hic_n));
      end
      $display("test over-current %0d done", limit);
   endtask : t_ocp

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tk(4);
      presetn <= 1'b1;
      t_startup();
      t_lv_uv();
      t_freeze();
      t_five(1'b0);
      t_five(1'b1);
      t_short();
      for (int k = 0; k < 3; k++) begin
         t_latch(k);
      end
      t_pwm();
      t_ocp(1'b1, 1'b0, rfs_pkg::OCP_LOW_LIMIT);
      t_ocp(1'b0, 1'b1, rfs_pkg::OCP_HIGH_LIMIT);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
